// ===== pfp_map.vh
// constants of the pulse fuse programming block: offsets, fields, resets, times
`ifndef PFP_MAP_VH
`define PFP_MAP_VH

// register byte offsets on the axi4-lite slave
`define PFP_OFF_STATUS      4'h0
`define PFP_OFF_CTRL        4'h4
`define PFP_OFF_FUSE        4'h8
`define PFP_OFF_PARAM       4'hC

// ctrl register fields and reset value
`define PFP_CTRL_EN_BIT     0
`define PFP_CTRL_RESET      32'h0000_0001

// status register field positions
`define PFP_ST_STATE_LSB    0
`define PFP_ST_KEY_LSB      4
`define PFP_ST_CODE_LSB     8
`define PFP_ST_LOCK_BIT     16
`define PFP_ST_HIGH_BIT     17
`define PFP_ST_MID_BIT      18

// fuse and param register field positions
`define PFP_SENS_LSB        0
`define PFP_QUIES_LSB       8
`define PFP_LOCK_FUSE_BIT   16

// register keys and code limits
`define PFP_KEY_SENS        3'h1
`define PFP_KEY_QUIES       3'h2
`define PFP_KEY_MAX         3'h7
`define PFP_SENS_MAX        6'h3F
`define PFP_QUIES_MAX       6'h20
`define PFP_LOCK_CODE       6'h20

// axi responses
`define PFP_RESP_OKAY       2'h0
`define PFP_RESP_SLVERR     2'h2

// timing: clock in mhz, pulse times in microseconds
`define PFP_CLK_MHZ         250
`define PFP_HIGH_WIDTH_US   30
`define PFP_MID_WIDTH_US    15
`define PFP_BURN_TIME_US    30
`define PFP_HIGH_CYC        (`PFP_HIGH_WIDTH_US * `PFP_CLK_MHZ)
`define PFP_MID_CYC         (`PFP_MID_WIDTH_US * `PFP_CLK_MHZ)
`define PFP_BURN_CYC        (`PFP_BURN_TIME_US * `PFP_CLK_MHZ)

`endif

// ===== pfp_prog_logic.v
// pulse-driven fuse programming logic of a linear sensor, with axi4-lite status port
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pfp_map.vh"

// What this block does
// - mid pulses in selection count as key; key 1 sensitivity, key 2 quiescent plus lock.
// - after selecting key 1 or 2, the next high pulse enters bit-field addressing; with any other key it returns to init.
// - in addressing each mid pulse falling edge adds one to code, saturating at max.
// - the current code drives the internal dac input in binary.
// - addressed value takes effect at once; only blown fuses make it permanent.
// - lsb is bit 0, equal to code 1 and key 1.
// - a blown fuse stays set forever; nothing clears it.
// - at power-up every unblown location returns to its initial zero value.
// - after power-up the initial state ignores mid pulses; one high pulse starts selection.
// - in addressing a further high pulse blows the addressed fuse; then power cycle needed.
// - sensitivity codes run from 0 to 63, six bits.
// - key 2 code 32 is the lock bit; once blown all programming is blocked.
module pfp_prog_logic #(
  parameter HIGH_CYC = `PFP_HIGH_CYC,
  parameter MID_CYC  = `PFP_MID_CYC,
  parameter BURN_CYC = `PFP_BURN_CYC,
  parameter CODE_W   = 6
) (
  input  wire              clk_sys_i,
  input  wire              rst_i,
  input  wire              ce_i,
  // level comparators on the sensor output pin
  input  wire              prog_high_level_i,
  input  wire              prog_mid_level_i,
  // fuse array state, read back from the fuses themselves
  input  wire [CODE_W-1:0] fuse_sens_i,
  input  wire [CODE_W-1:0] fuse_quies_i,
  input  wire              fuse_lock_i,
  // burn request to the fuse array
  output reg               fuse_burn_o,
  output reg  [2:0]        fuse_burn_key_o,
  output reg  [CODE_W-1:0] fuse_burn_bits_o,
  // dac code and effective parameters
  output reg  [CODE_W-1:0] dac_code_o,
  output reg  [CODE_W-1:0] sens_param_o,
  output reg  [CODE_W-1:0] quiescent_output_param_o,
  // axi4-lite slave
  input  wire [3:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [3:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready
);

  // programming states
  localparam ST_INIT   = 2'h0;
  localparam ST_SELECT = 2'h1;
  localparam ST_ADDR   = 2'h2;
  localparam ST_DONE   = 2'h3;

  // pin level classes
  localparam LV_LOW  = 2'h0;
  localparam LV_MID  = 2'h1;
  localparam LV_HIGH = 2'h2;

  localparam CNT_W = 16;
  localparam [CNT_W-1:0] HIGH_Q = HIGH_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] MID_Q  = MID_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] BURN_Q = BURN_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_SAT = {CNT_W{1'b1}};
  localparam [31:0]      CTRL_RST = `PFP_CTRL_RESET;  // sliced to the one enable bit

  // map an address to a register slot; 3'h4 means unmapped
  function [2:0] reg_slot;
    input [3:0] addr;
    begin
      case (addr)
        `PFP_OFF_STATUS: reg_slot = 3'h0;
        `PFP_OFF_CTRL:   reg_slot = 3'h1;
        `PFP_OFF_FUSE:   reg_slot = 3'h2;
        `PFP_OFF_PARAM:  reg_slot = 3'h3;
        default:         reg_slot = 3'h4;
      endcase
    end
  endfunction

  // highest code a register key accepts
  function [CODE_W-1:0] key_max;
    input [2:0] key;
    begin
      key_max = (key == `PFP_KEY_SENS) ? `PFP_SENS_MAX : `PFP_QUIES_MAX;
    end
  endfunction

  reg [1:0]        state;
  reg [2:0]        key;
  reg [CODE_W-1:0] code;
  reg [1:0]        level;
  reg [CNT_W-1:0]  lvl_cnt;
  reg              saw_high;
  reg              ctrl_en;
  reg              high_ev;
  reg              mid_ev;
  reg              burn_ok;
  reg [1:0]        next_level;

  ////////////////////////////////////////////////////////////////////////////
  // pulse decoding

  // classify the pin; high comparator wins since a high pulse passes mid
  always @* begin
    if (prog_high_level_i)
      next_level = LV_HIGH;
    else if (prog_mid_level_i)
      next_level = LV_MID;
    else
      next_level = LV_LOW;
  end

  // dwell counter per level; events fire on the falling edge of a held level
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      level    <= LV_LOW;
      lvl_cnt  <= {CNT_W{1'b0}};
      saw_high <= 1'b0;
      high_ev  <= 1'b0;
      mid_ev   <= 1'b0;
      burn_ok  <= 1'b0;
    end else if (ce_i) begin
      high_ev <= 1'b0;
      mid_ev  <= 1'b0;
      level   <= next_level;
      if (next_level != level) begin
        lvl_cnt <= {CNT_W{1'b0}};
        // a high level counts only once held long enough
        if (level == LV_HIGH && lvl_cnt >= HIGH_Q) begin
          high_ev <= 1'b1;
          burn_ok <= (lvl_cnt >= BURN_Q);
        end
        // mid counted on its fall to low, unless part of a high pulse
        if (level == LV_MID && next_level == LV_LOW && !saw_high && lvl_cnt >= MID_Q)
          mid_ev <= 1'b1;
      end else if (lvl_cnt != CNT_SAT) begin
        lvl_cnt <= lvl_cnt + 1'b1;
      end
      // the high flag spans a whole pulse, from first rise to return to low
      if (next_level == LV_HIGH)
        saw_high <= 1'b1;
      else if (next_level == LV_LOW)
        saw_high <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // programming state machine

  // rst_i stands for the supply cycle: trial code and key return to zero
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state            <= ST_INIT;
      key              <= 3'h0;
      code             <= {CODE_W{1'b0}};
      fuse_burn_o      <= 1'b0;
      fuse_burn_key_o  <= 3'h0;
      fuse_burn_bits_o <= {CODE_W{1'b0}};
    end else if (ce_i) begin
      fuse_burn_o <= 1'b0;
      // a blown lock fuse or a software disable freezes all programming
      if (!fuse_lock_i && ctrl_en) begin
        case (state)
          ST_INIT: begin
            // mid pulses are ignored here
            if (high_ev)
              state <= ST_SELECT;
          end
          ST_SELECT: begin
            if (mid_ev && key != `PFP_KEY_MAX)
              key <= key + 3'h1;
            if (high_ev) begin
              if (key == `PFP_KEY_SENS || key == `PFP_KEY_QUIES)
                state <= ST_ADDR;
              else begin
                state <= ST_INIT;
                key   <= 3'h0;
              end
            end
          end
          ST_ADDR: begin
            if (mid_ev && code != key_max(key))
              code <= code + 1'b1;
            if (high_ev && burn_ok) begin
              fuse_burn_o      <= 1'b1;
              fuse_burn_key_o  <= key;
              fuse_burn_bits_o <= code;
              state            <= ST_DONE;
            end
          end
          ST_DONE: state <= ST_DONE;
          default: state <= ST_INIT;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parameter outputs

  // trial code ors onto blown fuses; fuses are never masked, so blown bits hold
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dac_code_o               <= {CODE_W{1'b0}};
      sens_param_o             <= {CODE_W{1'b0}};
      quiescent_output_param_o <= {CODE_W{1'b0}};
    end else if (ce_i) begin
      dac_code_o   <= code;
      sens_param_o <= fuse_sens_i |
                      ((state != ST_INIT && key == `PFP_KEY_SENS) ? code : {CODE_W{1'b0}});
      // the lock code is not a quiescent value, so it never reaches that dac
      quiescent_output_param_o <= fuse_quies_i |
                      ((state != ST_INIT && key == `PFP_KEY_QUIES && code != `PFP_LOCK_CODE)
                       ? code : {CODE_W{1'b0}});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  reg        aw_held;
  reg [3:0]  aw_addr;
  reg        w_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  wire       wr_fire;
  reg [31:0] rd_word;

  // write address and data are each taken once into a holding stage; read address is not held; no new ones while a reply waits
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  // address and data may arrive in either order
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held     <= 1'b0;
      aw_addr     <= 4'h0;
      w_held      <= 1'b0;
      w_data      <= 32'h0000_0000;
      w_strb      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PFP_RESP_OKAY;
      ctrl_en     <= CTRL_RST[`PFP_CTRL_EN_BIT];
    end else if (ce_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // only ctrl is writable; other mapped words ignore writes
        s_axi_bresp <= (reg_slot(aw_addr) == 3'h4) ? `PFP_RESP_SLVERR : `PFP_RESP_OKAY;
        if (reg_slot(aw_addr) == 3'h1 && w_strb[0])
          ctrl_en <= w_data[`PFP_CTRL_EN_BIT];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux of the block's own state
  always @* begin
    rd_word = 32'h0000_0000;
    case (reg_slot(s_axi_araddr))
      3'h0: begin
        rd_word[`PFP_ST_STATE_LSB +: 2]    = state;
        rd_word[`PFP_ST_KEY_LSB +: 3]      = key;
        rd_word[`PFP_ST_CODE_LSB +: CODE_W] = code;
        rd_word[`PFP_ST_LOCK_BIT]          = fuse_lock_i;
        rd_word[`PFP_ST_HIGH_BIT]          = (level == LV_HIGH);
        rd_word[`PFP_ST_MID_BIT]           = (level == LV_MID);
      end
      3'h1: rd_word[`PFP_CTRL_EN_BIT] = ctrl_en;
      3'h2: begin
        rd_word[`PFP_SENS_LSB +: CODE_W]  = fuse_sens_i;
        rd_word[`PFP_QUIES_LSB +: CODE_W] = fuse_quies_i;
        rd_word[`PFP_LOCK_FUSE_BIT]       = fuse_lock_i;
      end
      3'h3: begin
        rd_word[`PFP_SENS_LSB +: CODE_W]  = sens_param_o;
        rd_word[`PFP_QUIES_LSB +: CODE_W] = quiescent_output_param_o;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // read answer one cycle after the address is taken
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `PFP_RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp <= (reg_slot(s_axi_araddr) == 3'h4) ? `PFP_RESP_SLVERR : `PFP_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // pfp_prog_logic

// ===== pfp_prog_logic_props.sv
// checker for the pulse fuse programming block
`timescale 1ns/1ps
module pfp_prog_logic_props #(
  parameter BURN_CYC = 20
) (
  input wire       clk_sys_i,
  input wire       rst_i,
  input wire       prog_high_level_i,
  input wire [5:0] fuse_sens_i,
  input wire [5:0] fuse_quies_i,
  input wire       fuse_lock_i,
  input wire       fuse_burn_o,
  input wire [2:0] fuse_burn_key_o,
  input wire [5:0] fuse_burn_bits_o,
  input wire [5:0] dac_code_o,
  input wire [5:0] sens_param_o,
  input wire [5:0] quiescent_output_param_o,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire [1:0] s_axi_rresp
);
  reg [15:0] run;
  reg [15:0] last_run;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////////////
  // length of the latest high excursion, so a burn can be tied to it
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      run      <= 16'h0000;
      last_run <= 16'h0000;
    end else if (prog_high_level_i) begin
      run <= run + 16'h0001;
    end else if (run != 16'h0000) begin
      last_run <= run;
      run      <= 16'h0000;
    end
  end
  a_burn_single: assert property (fuse_burn_o |=> !fuse_burn_o)
    else $error("burn request longer than one cycle");
  a_burn_long: assert property (fuse_burn_o |-> last_run >= BURN_CYC)
    else $error("burn after a short high pulse");
  a_burn_code: assert property (fuse_burn_o |-> fuse_burn_bits_o == dac_code_o
    && (fuse_burn_key_o == 3'h1 || fuse_burn_key_o == 3'h2))
    else $error("burn of a code other than the addressed one");
  a_lock_block: assert property (fuse_lock_i && $past(fuse_lock_i) |-> !fuse_burn_o)
    else $error("burn while locked");
  // after reset outputs may lag two edges, so both are skipped
  a_code_step: assert property (!$past(rst_i) && !$past(rst_i, 2)
    && dac_code_o != $past(dac_code_o) |-> dac_code_o == $past(dac_code_o) + 6'h01)
    else $error("code moved by other than one");
  a_sens_keep: assert property (!$past(rst_i) && !$past(rst_i, 2)
    && $stable(fuse_sens_i) |-> (sens_param_o & fuse_sens_i) == fuse_sens_i)
    else $error("blown sensitivity bit lost");
  a_quies_keep: assert property (!$past(rst_i) && !$past(rst_i, 2)
    && $stable(fuse_quies_i) |-> (quiescent_output_param_o & fuse_quies_i) == fuse_quies_i)
    else $error("blown quiescent bit lost");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  c_burn: cover property (fuse_burn_o);
  c_code_max: cover property (dac_code_o == 6'h3F);
  c_read_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // pfp_prog_logic_props

// ===== pfp_programmer.sv
// programmer model: drives the pin level comparators with pulse trains
`timescale 1ns/1ps
module pfp_programmer #(
  parameter HW  = 24,
  parameter MW  = 12,
  parameter GAP = 8
) (
  input  wire clk_sys_i,
  output reg  prog_high_level_o,
  output reg  prog_mid_level_o
);
  // pin rests at the low level between pulses
  initial begin
    prog_high_level_o = 1'b0;
    prog_mid_level_o  = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one pulse then the low gap; a high level also trips the mid comparator
  task pulse(input reg hi, input integer len);
    begin
      @(posedge clk_sys_i);
      prog_high_level_o <= hi;
      prog_mid_level_o  <= 1'b1;
      repeat (len) @(posedge clk_sys_i);
      prog_high_level_o <= 1'b0;
      prog_mid_level_o  <= 1'b0;
      repeat (GAP) @(posedge clk_sys_i);
    end
  endtask
  // high, key mids, high, code mids, with no power drop between
  task address(input integer key, input integer code);
    begin
      pulse(1'b1, HW);
      repeat (key) pulse(1'b0, MW);
      pulse(1'b1, HW);
      repeat (code) pulse(1'b0, MW);
    end
  endtask
endmodule // pfp_programmer

// ===== pfp_prog_logic_bench.sv
// testbench of the pulse fuse programming block
`timescale 1ns/1ps
`include "pfp_map.vh"
`define PFP_TB_CHK(n, e, v) begin compares = compares + 1; if ((v) !== (e)) begin \
  bad_count = bad_count + 1; $display("CHECK FAILED %s exp %0h got %0h", n, e, v); end end
module pfp_prog_logic_bench;
  reg         clk_sys_i, rst_i, ce_i, fuse_lock_i;
  reg  [5:0]  fuse_sens_i, fuse_quies_i;
  wire        prog_high_level_i, prog_mid_level_i, fuse_burn_o;
  wire [2:0]  fuse_burn_key_o;
  wire [5:0]  fuse_burn_bits_o, dac_code_o, sens_param_o, quiescent_output_param_o;
  reg  [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  reg  [31:0] s_axi_wdata, rd;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  reg  [1:0]  rs;
  integer     bad_count, compares;
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // short counts keep each pulse to tens of cycles
  pfp_prog_logic #(.HIGH_CYC(20), .MID_CYC(10), .BURN_CYC(20)) pfp_prog_logic_i (.*);
  pfp_programmer pfp_programmer_i (.clk_sys_i(clk_sys_i),
    .prog_high_level_o(prog_high_level_i), .prog_mid_level_o(prog_mid_level_i));
  // fuse array lives outside the logic: survives reset, only gains bits
  always @(posedge clk_sys_i) begin
    if (fuse_burn_o && fuse_burn_key_o == `PFP_KEY_SENS)
      fuse_sens_i <= fuse_sens_i | fuse_burn_bits_o;
    else if (fuse_burn_o && fuse_burn_bits_o == `PFP_LOCK_CODE)
      fuse_lock_i <= 1'b1;
    else if (fuse_burn_o)
      fuse_quies_i <= fuse_quies_i | fuse_burn_bits_o;
  end
  task end_of_test;
    begin
      if (bad_count == 0 && compares > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // write one word; each channel held until its ready is sampled
  task axi_wr(input [3:0] a, input [31:0] d);
    integer i;
    reg     done;
    begin
      done = 1'b0;
      @(posedge clk_sys_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (i = 0; i < 64 && !done; i = i + 1) begin
        @(posedge clk_sys_i);
        if (s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready)
          s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          rs = s_axi_bresp;
          s_axi_bready <= 1'b0;
          done = 1'b1;
        end
      end
      if (!done) begin
        bad_count = bad_count + 1;
        end_of_test;
      end
    end
  endtask
  // read one word into rd and rs
  task axi_rd(input [3:0] a);
    integer i;
    reg     done;
    begin
      done = 1'b0;
      @(posedge clk_sys_i);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (i = 0; i < 64 && !done; i = i + 1) begin
        @(posedge clk_sys_i);
        if (s_axi_arready)
          s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          rd = s_axi_rdata;
          rs = s_axi_rresp;
          s_axi_rready <= 1'b0;
          done = 1'b1;
        end
      end
      if (!done) begin
        bad_count = bad_count + 1;
        end_of_test;
      end
    end
  endtask
  task st_chk(input [1:0] e);
    begin
      axi_rd(`PFP_OFF_STATUS);
      `PFP_TB_CHK("state", e, rd[1:0])
    end
  endtask
  // supply drop: trial codes go, fuses stay
  task power_cycle;
    begin
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
    end
  endtask
  initial begin
    {rst_i, ce_i, fuse_lock_i, s_axi_awvalid, s_axi_wvalid} = 5'h18;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, rd, rs} = 37'h0;
    {fuse_sens_i, fuse_quies_i, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
    s_axi_wstrb = 4'hF;
    bad_count = 0;
    compares = 0;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    axi_rd(`PFP_OFF_CTRL);
    `PFP_TB_CHK("ctrl", `PFP_CTRL_RESET, rd)
    axi_rd(4'h6);
    `PFP_TB_CHK("resp", `PFP_RESP_SLVERR, rs)
    pfp_programmer_i.pulse(1'b0, 12);
    st_chk(2'h0);
    // a frozen clock enable must swallow a whole high pulse
    ce_i <= 1'b0;
    pfp_programmer_i.pulse(1'b1, 24);
    ce_i <= 1'b1;
    st_chk(2'h0);
    pfp_programmer_i.pulse(1'b1, 24);
    st_chk(2'h1);
    pfp_programmer_i.pulse(1'b0, 5);
    pfp_programmer_i.pulse(1'b0, 12);
    st_chk(2'h1);
    `PFP_TB_CHK("key", `PFP_KEY_SENS, rd[6:4])
    pfp_programmer_i.pulse(1'b1, 24);
    repeat (5) pfp_programmer_i.pulse(1'b0, 12);
    st_chk(2'h2);
    `PFP_TB_CHK("dac", 6'h05, dac_code_o)
    `PFP_TB_CHK("sens", 6'h05, sens_param_o)
    pfp_programmer_i.pulse(1'b1, 24);
    `PFP_TB_CHK("burn", 9'h045, {fuse_burn_key_o, fuse_burn_bits_o})
    pfp_programmer_i.pulse(1'b0, 12);
    st_chk(2'h3);
    `PFP_TB_CHK("dac", 6'h05, dac_code_o)
    power_cycle;
    `PFP_TB_CHK("dac", 6'h00, dac_code_o)
    pfp_programmer_i.address(1, 64);
    `PFP_TB_CHK("dac", `PFP_SENS_MAX, dac_code_o)
    `PFP_TB_CHK("sens", 6'h3F, sens_param_o)
    power_cycle;
    `PFP_TB_CHK("sens", 6'h05, sens_param_o)
    axi_wr(`PFP_OFF_CTRL, 32'h0);
    pfp_programmer_i.pulse(1'b1, 24);
    st_chk(2'h0);
    axi_wr(`PFP_OFF_CTRL, 32'h1);
    `PFP_TB_CHK("resp", `PFP_RESP_OKAY, rs)
    pfp_programmer_i.address(2, 15);
    `PFP_TB_CHK("quies", 6'h0F, quiescent_output_param_o)
    repeat (18) pfp_programmer_i.pulse(1'b0, 12);
    `PFP_TB_CHK("dac", `PFP_QUIES_MAX, dac_code_o)
    `PFP_TB_CHK("quies", 6'h00, quiescent_output_param_o)
    pfp_programmer_i.pulse(1'b1, 24);
    power_cycle;
    axi_rd(`PFP_OFF_FUSE);
    `PFP_TB_CHK("lock", 1'b1, rd[`PFP_LOCK_FUSE_BIT])
    pfp_programmer_i.pulse(1'b1, 24);
    st_chk(2'h0);
    end_of_test;
  end
endmodule // pfp_prog_logic_bench
bind pfp_prog_logic pfp_prog_logic_props #(.BURN_CYC(BURN_CYC)) pfp_prog_logic_props_i (.*);
